// ===== logic/mnpb_pkg.sv
package mnpb_pkg;
  // entry counts and table indices
  localparam int MNPB_S16_N = 9;
  localparam int MNPB_L32_N = 4;
  localparam int MNPB_IX_VOLT = 0;
  localparam int MNPB_IX_FREQ = 1;
  localparam int MNPB_IX_PF = 2;
  localparam int MNPB_IX_SPD1 = 3;
  localparam int MNPB_IX_SPD2 = 4;
  localparam int MNPB_IX_EFF = 5;
  localparam int MNPB_IX_RES = 6;
  localparam int MNPB_IX_CTP = 7;
  localparam int MNPB_IX_CTS = 8;
  localparam int MNPB_IX_W1 = 0;
  localparam int MNPB_IX_W2 = 1;
  localparam int MNPB_IX_HP1 = 2;
  localparam int MNPB_IX_HP2 = 3;

  // 16-bit words: volt, freq, pf, speed1, speed2, efficiency, stator res, ct primary, ct secondary
  localparam logic [15:0] MNPB_S16_ADDR [0:8] = '{16'h0387, 16'h0388, 16'h0391, 16'h0392, 16'h0393,
    16'h0394, 16'h0395, 16'h0396, 16'h0397};
  localparam logic [15:0] MNPB_S16_RST [0:8] = '{16'h01e0, 16'h003c, 16'h209e, 16'h06d6, 16'h06d6,
    16'h2134, 16'h0118, 16'h0001, 16'h0001};
  localparam logic [15:0] MNPB_S16_MIN [0:8] = '{16'h0064, 16'h0032, 16'h1388, 16'h012c, 16'h012c,
    16'h1388, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] MNPB_S16_MAX [0:8] = '{16'h1388, 16'h003c, 16'h2710, 16'h0e10, 16'h0e10,
    16'h2710, 16'hffff, 16'hffff, 16'hffff};
  // power factor is the only signed word
  localparam logic [8:0] MNPB_S16_SIGNED = 9'h004;

  // 32-bit pairs: watts1, watts2, hp1 x100, hp2 x100; high word at the base address
  localparam logic [15:0] MNPB_L32_ADDR [0:3] = '{16'h0389, 16'h038b, 16'h038d, 16'h038f};
  localparam logic [31:0] MNPB_L32_RST [0:3] = '{32'h00003a42, 32'h00003a42, 32'h000007d0, 32'h000007d0};
  localparam logic [31:0] MNPB_L32_MIN [0:3] = '{32'h0000000a, 32'h0000000a, 32'h00000001, 32'h00000001};
  localparam logic [31:0] MNPB_L32_MAX [0:3] = '{32'h0038e474, 32'h0038e474, 32'h0007a120, 32'h0007a120};

  // watts to hp x100 is x1000/7457, the reverse x7457/1000
  localparam logic [15:0] MNPB_CONV_MUL [0:3] = '{16'h03e8, 16'h03e8, 16'h1d21, 16'h1d21};
  localparam logic [15:0] MNPB_CONV_DIV [0:3] = '{16'h1d21, 16'h1d21, 16'h03e8, 16'h03e8};
  localparam logic [1:0] MNPB_CONV_PAIR = 2'h2;
  localparam logic [15:0] MNPB_CT_UNITY = 16'h0001;
  localparam int MNPB_DIV_W = 32;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] data;
  } mnpb_req_t;

  typedef struct packed {
    logic [8:0][15:0] s16;
    logic [3:0][31:0] l32;
  } mnpb_image_t;

  typedef enum logic [0:0] {
    MNPB_ST_IDLE = 1'b0,
    MNPB_ST_CONV = 1'b1
  } mnpb_state_t;
endpackage

// ===== logic/mnpb_range_chk.sv
`timescale 1ns/1ns
module mnpb_range_chk import mnpb_pkg::*; (
  input wire logic i_is_long, // value is a 32-bit pair
  input wire logic [3:0] i_idx, // table index of the target
  input wire logic [31:0] i_value, // candidate value
  output logic o_in_range // value lies inside the span
);
  logic [31:0] lo_bound;
  logic [31:0] hi_bound;
  logic neg_signed;

  // bounds from the tables; a negative signed word is always below its span
  assign lo_bound = i_is_long ? MNPB_L32_MIN[i_idx[1:0]] : {16'h0000, MNPB_S16_MIN[i_idx]};
  assign hi_bound = i_is_long ? MNPB_L32_MAX[i_idx[1:0]] : {16'h0000, MNPB_S16_MAX[i_idx]};
  assign neg_signed = !i_is_long && MNPB_S16_SIGNED[i_idx] && i_value[15];
  assign o_in_range = !neg_signed && (i_value >= lo_bound) && (i_value <= hi_bound);
endmodule // mnpb_range_chk

// ===== logic/mnpb_divider.sv
`timescale 1ns/1ns
module mnpb_divider #(
  parameter int W = 32
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_start, // take operands, ignored while busy
  input wire logic [W-1:0] i_dividend, // numerator
  input wire logic [W-1:0] i_divisor, // denominator, never zero here
  output logic o_busy, // iterating
  output logic o_done, // one-cycle pulse, quotient valid
  output logic [W-1:0] o_quot // quotient
);
  localparam int STEP_W = $clog2(W);
  logic [W:0] rem;
  logic [W-1:0] dvsr;
  logic [STEP_W-1:0] step;
  logic [W:0] shifted;
  logic [W:0] trial;

  // one quotient bit per clock keeps the timing easy at 250 mhz
  assign shifted = {rem[W-1:0], o_quot[W-1]};
  assign trial = shifted - {1'b0, dvsr};

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_quot <= '0;
      rem <= '0;
      dvsr <= '0;
      step <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        o_quot <= i_dividend;
        rem <= '0;
        dvsr <= i_divisor;
        step <= '0;
      end else if (o_busy) begin
        rem <= trial[W] ? shifted : trial;
        o_quot <= {o_quot[W-2:0], !trial[W]};
        step <= step + 1'b1;
        if (step == STEP_W'(W - 1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule // mnpb_divider

// ===== logic/mnpb_nameplate_bank.sv
`timescale 1ns/1ns
// Contract
// - rated voltage is an unsigned 16-bit volt value, default 480, accepted from 100 to 5000.
// - rated frequency is an unsigned 16-bit hertz value, default 60, accepted from 50 to 60.
// - winding 1 power is an unsigned 32-bit watt value, default 14914, accepted from 10 to 3728500.
// - a new winding 1 watt value recomputes and updates the winding 1 horsepower word.
// - winding 2 power is a 32-bit watt value like winding 1, used only by two-winding profiles.
// - a new winding 2 watt value recomputes and updates the winding 2 horsepower word.
// - winding 1 horsepower is unsigned 32-bit in hundredths, default 2000, accepted from 1 to 500000.
// - a new winding 1 horsepower value recomputes and updates the winding 1 watt word.
// - winding 2 horsepower uses the same scaling and span, and writing it updates winding 2 watts.
// - power factor is a signed 16-bit value in 0.01 percent, default 8350, accepted 5000 to 10000.
// - each winding speed is an unsigned 16-bit rpm value, default 1750, accepted 300 to 3600.
// - efficiency is an unsigned 16-bit value in 0.01 percent, default 8500, accepted 5000 to 10000.
// - stator resistance is an unsigned 16-bit milliohm value with default 280.
// - current transformer ratio terms default to 1 and take effect only with external transformers.
module mnpb_nameplate_bank import mnpb_pkg::*; (
  input wire logic i_clk_sys, // system clock, 250 mhz
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire mnpb_req_t i_req, // holding-register request, one per cycle
  output logic o_ack, // answer strobe, one cycle after the request
  output logic o_err, // request refused, valid with o_ack
  output logic [15:0] o_rdata, // read word, valid with o_ack
  output logic o_busy, // conversion running, writes refused
  input wire logic i_nv_restore, // load the image from nonvolatile store
  input wire mnpb_image_t i_nv_image, // image held in nonvolatile store
  output mnpb_image_t o_image, // live image, to the store and the motor logic
  output logic o_nv_save, // one-cycle pulse, image changed
  input wire logic i_ext_ct_fitted, // external current transformers fitted
  output logic [15:0] o_ct_primary, // effective ct primary term
  output logic [15:0] o_ct_secondary // effective ct secondary term
);
  logic [15:0] s16_q [0:MNPB_S16_N-1];
  logic [31:0] l32_q [0:MNPB_L32_N-1];
  logic [MNPB_S16_N-1:0] hit16;
  logic [MNPB_L32_N-1:0] hit_hi;
  logic [MNPB_L32_N-1:0] hit_lo;
  logic [3:0] idx16;
  logic [1:0] idx32;
  logic any16;
  logic any_hi;
  logic any_lo;
  logic in_range;
  logic [31:0] chk_value;
  logic [3:0] chk_idx;
  logic wr_base;
  logic commit16;
  logic stage_hi;
  logic commit32;
  logic wr_refused;
  logic rd_miss;
  logic [15:0] next_rdata;
  logic hi_pend;
  logic [1:0] hi_idx;
  logic [15:0] hi_data;
  logic [31:0] wr_value;
  logic [47:0] conv_prod;
  mnpb_state_t state;
  mnpb_state_t next_state;
  logic [1:0] conv_tgt;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;
  logic [31:0] conv_val;
  logic conv_store;

  // address decode and the stored words, one generate per entry
  genvar g;
  for (g = 0; g < MNPB_S16_N; g++) begin : gen_s16
    assign hit16[g] = (i_req.addr == MNPB_S16_ADDR[g]);
    assign o_image.s16[g] = s16_q[g];
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        s16_q[g] <= MNPB_S16_RST[g];
      end else if (i_nv_restore) begin
        s16_q[g] <= i_nv_image.s16[g];
      end else if (commit16 && idx16 == 4'(g)) begin
        s16_q[g] <= i_req.data;
      end
    end
  end

  for (g = 0; g < MNPB_L32_N; g++) begin : gen_l32
    assign hit_hi[g] = (i_req.addr == MNPB_L32_ADDR[g]);
    assign hit_lo[g] = (i_req.addr == MNPB_L32_ADDR[g] + 16'h0001);
    assign o_image.l32[g] = l32_q[g];
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        l32_q[g] <= MNPB_L32_RST[g];
      end else if (i_nv_restore) begin
        l32_q[g] <= i_nv_image.l32[g];
      end else if (commit32 && idx32 == 2'(g)) begin
        l32_q[g] <= wr_value;
      end else if (conv_store && conv_tgt == 2'(g)) begin
        l32_q[g] <= conv_val;
      end
    end
  end

  // index encoders for the decoded hit
  always_comb begin
    idx16 = 4'h0;
    idx32 = 2'h0;
    for (int k = 0; k < MNPB_S16_N; k++) begin
      if (hit16[k]) begin
        idx16 = 4'(k);
      end
    end
    for (int k = 0; k < MNPB_L32_N; k++) begin
      if (hit_hi[k] || hit_lo[k]) begin
        idx32 = 2'(k);
      end
    end
  end

  assign any16 = |hit16;
  assign any_hi = |hit_hi;
  assign any_lo = |hit_lo;

  // a pair is checked whole, so the span applies to the joined value
  assign wr_value = {hi_data, i_req.data};
  assign chk_value = any_lo ? wr_value : {16'h0000, i_req.data};
  assign chk_idx = any_lo ? {2'b00, idx32} : idx16;

  mnpb_range_chk u_range (
    .i_is_long(any_lo),
    .i_idx(chk_idx),
    .i_value(chk_value),
    .o_in_range(in_range)
  );

  // write qualification; a restore or a running conversion locks writes out
  assign wr_base = i_req.wr && !o_busy && !i_nv_restore;
  assign commit16 = wr_base && any16 && in_range;
  assign stage_hi = wr_base && any_hi;
  assign commit32 = wr_base && any_lo && hi_pend && (hi_idx == idx32) && in_range;
  assign wr_refused = i_req.wr && !(commit16 || stage_hi || commit32);
  assign rd_miss = i_req.rd && !i_req.wr && !(any16 || any_hi || any_lo);

  // read mux: high word at the base address, low word one above
  assign next_rdata = any16 ? s16_q[idx16] :
                      any_hi ? l32_q[idx32][31:16] :
                      any_lo ? l32_q[idx32][15:0] : 16'h0000;

  // answer flops, every request gets exactly one ack one cycle later
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_ack <= i_req.wr || i_req.rd;
      o_err <= wr_refused || rd_miss;
      o_rdata <= i_req.rd ? next_rdata : 16'h0000;
    end
  end

  // high-word staging; any other write breaks the pair so halves never mix
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_nv_restore) begin
      hi_pend <= 1'b0;
      hi_idx <= 2'h0;
      hi_data <= 16'h0000;
    end else if (stage_hi) begin
      hi_pend <= 1'b1;
      hi_idx <= idx32;
      hi_data <= i_req.data;
    end else if (i_req.wr) begin
      hi_pend <= 1'b0;
    end
  end

  // watts and horsepower convert through one shared divider
  assign conv_prod = wr_value * MNPB_CONV_MUL[idx32];

  mnpb_divider #(
    .W(MNPB_DIV_W)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_start(commit32),
    .i_dividend(conv_prod[31:0]),
    .i_divisor({16'h0000, MNPB_CONV_DIV[idx32]}),
    .o_busy(div_busy),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // a horsepower entry of 1 (0.01 hp) gives 7 W, below the watt span, so results are clamped
  assign conv_val = (div_quot < MNPB_L32_MIN[conv_tgt]) ? MNPB_L32_MIN[conv_tgt] :
                    (div_quot > MNPB_L32_MAX[conv_tgt]) ? MNPB_L32_MAX[conv_tgt] : div_quot;
  assign conv_store = (state == MNPB_ST_CONV) && div_done;

  // conversion sequencer
  always_comb begin
    case (state)
      MNPB_ST_IDLE: next_state = commit32 ? MNPB_ST_CONV : MNPB_ST_IDLE;
      MNPB_ST_CONV: next_state = div_done ? MNPB_ST_IDLE : MNPB_ST_CONV;
      default: next_state = MNPB_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_nv_restore) begin
      state <= MNPB_ST_IDLE;
      conv_tgt <= 2'h0;
    end else begin
      state <= next_state;
      if (commit32) begin
        conv_tgt <= idx32 ^ MNPB_CONV_PAIR;
      end
    end
  end

  // a restored image may abandon a conversion; the divider must drain first
  assign o_busy = (state == MNPB_ST_CONV) || div_busy;

  // save request and effective transformer terms
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_nv_save <= 1'b0;
      o_ct_primary <= MNPB_CT_UNITY;
      o_ct_secondary <= MNPB_CT_UNITY;
    end else begin
      o_nv_save <= commit16 || commit32 || conv_store;
      o_ct_primary <= i_ext_ct_fitted ? s16_q[MNPB_IX_CTP] : MNPB_CT_UNITY;
      o_ct_secondary <= i_ext_ct_fitted ? s16_q[MNPB_IX_CTS] : MNPB_CT_UNITY;
    end
  end

  // helper for the conversion checks: expected result taken at commit
  logic [31:0] exp_q;
  logic [47:0] exp_div;
  assign exp_div = (48'(wr_value) * 48'(MNPB_CONV_MUL[idx32])) / 48'(MNPB_CONV_DIV[idx32]);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      exp_q <= 32'h00000000;
    end else if (commit32) begin
      exp_q <= exp_div[31:0];
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  AST_RST_VOLT: assert property ($fell(i_sys_rst) |->
    s16_q[MNPB_IX_VOLT] == 16'h01e0 && s16_q[MNPB_IX_FREQ] == 16'h003c)
    else $error("voltage or frequency default wrong after reset");

  AST_FREQ_REJECT: assert property (i_req.wr && !o_busy && !i_nv_restore &&
    i_req.addr == 16'h0388 && i_req.data > 16'h003c |=> o_ack && o_err && $stable(s16_q[MNPB_IX_FREQ]))
    else $error("out-of-span frequency write was taken");

  AST_W1_SPAN: assert property (commit32 && idx32 == 2'h0 |=>
    l32_q[MNPB_IX_W1] >= 32'h0000000a && l32_q[MNPB_IX_W1] <= 32'h0038e474)
    else $error("winding 1 watts outside span after write");

  AST_W1_TO_HP: assert property (commit32 && idx32 == 2'h0 |=>
    o_busy [*8] ##[22:28] (l32_q[MNPB_IX_HP1] == $past(exp_q)))
    else $error("winding 1 horsepower not recomputed from watts");

  AST_W2_TO_HP: assert property (commit32 && idx32 == 2'h1 |->
    ##[30:36] (l32_q[MNPB_IX_HP2] == exp_q && !o_busy))
    else $error("winding 2 horsepower not recomputed from watts");

  AST_HP1_TO_W: assert property (commit32 && idx32 == 2'h2 && wr_value >= 32'h00000002 |->
    ##[30:36] (l32_q[MNPB_IX_W1] == exp_q && o_nv_save))
    else $error("winding 1 watts not recomputed from horsepower");

  AST_HP2_SPAN: assert property (i_req.wr && !o_busy && !i_nv_restore && any_lo && idx32 == 2'h3 &&
    wr_value > 32'h0007a120 |=> o_err && $stable(l32_q[MNPB_IX_HP2]))
    else $error("winding 2 horsepower above span was taken");

  AST_PF_NEG: assert property (i_req.wr && !i_nv_restore && i_req.addr == 16'h0391 && i_req.data[15] |=>
    o_err && $stable(s16_q[MNPB_IX_PF]))
    else $error("negative power factor was taken");

  AST_SPD_LOW: assert property (i_req.wr && !i_nv_restore && hit16[MNPB_IX_SPD1] && i_req.data < 16'h012c |=>
    o_err && $stable(s16_q[MNPB_IX_SPD1]))
    else $error("speed below span was taken");

  AST_CT_UNITY: assert property (!i_ext_ct_fitted |=> o_ct_primary == 16'h0001 &&
    o_ct_secondary == 16'h0001)
    else $error("ct terms used without external transformers");

  AST_LO_ALONE: assert property (i_req.wr && any_lo && !hi_pend |=> o_ack && o_err)
    else $error("low word without staged high word was taken");

  AST_RESTORE: assert property (i_nv_restore |=>
    s16_q[MNPB_IX_EFF] == $past(i_nv_image.s16[MNPB_IX_EFF]) && l32_q[MNPB_IX_W2] == $past(i_nv_image.l32[MNPB_IX_W2]))
    else $error("restore did not load the stored image");

  // answers, spans, conversions and read-back; a restore may overwrite any word, so $stable checks exclude it
  AST_ACK_EACH: assert property (i_req.wr || i_req.rd |=>
    o_ack)
    else $error("request was not answered in the next cycle");

  AST_VOLT_LOW: assert property (i_req.wr && !o_busy && !i_nv_restore && hit16[MNPB_IX_VOLT] &&
    i_req.data < 16'h0064 |=> o_err && $stable(s16_q[MNPB_IX_VOLT]))
    else $error("voltage below span was taken");

  AST_W2_SPAN: assert property (commit32 && idx32 == 2'h1 |=>
    l32_q[MNPB_IX_W2] >= 32'h0000000a && l32_q[MNPB_IX_W2] <= 32'h0038e474)
    else $error("winding 2 watts outside span after write");

  AST_HP1_ZERO: assert property (i_req.wr && !o_busy && !i_nv_restore && hit_lo[MNPB_IX_HP1] &&
    wr_value == 32'h00000000 |=> o_err && $stable(l32_q[MNPB_IX_HP1]))
    else $error("zero winding 1 horsepower was taken");

  AST_HP2_TO_W: assert property (commit32 && idx32 == 2'h3 && wr_value >= 32'h00000002 |->
    ##[30:36] (l32_q[MNPB_IX_W2] == exp_q && !o_busy))
    else $error("winding 2 watts not recomputed from horsepower");

  AST_W2_CLAMP: assert property (commit32 && idx32 == 2'h3 && wr_value == 32'h00000001 |->
    ##[30:36] (l32_q[MNPB_IX_W2] == 32'h0000000a && !o_busy))
    else $error("winding 2 watts from the smallest horsepower not clamped to span");

  AST_EFF_HIGH: assert property (i_req.wr && !i_nv_restore && hit16[MNPB_IX_EFF] && i_req.data > 16'h2710 |=>
    o_err && $stable(s16_q[MNPB_IX_EFF]))
    else $error("efficiency above span was taken");

  AST_RES_ANY: assert property (i_req.wr && !o_busy && !i_nv_restore && hit16[MNPB_IX_RES] |=>
    o_ack && !o_err && s16_q[MNPB_IX_RES] == $past(i_req.data))
    else $error("stator resistance write was refused or lost");

  AST_CT_FIT: assert property (i_ext_ct_fitted |=> o_ct_primary == $past(s16_q[MNPB_IX_CTP]) &&
    o_ct_secondary == $past(s16_q[MNPB_IX_CTS]))
    else $error("stored ct terms not passed with external transformers");

  AST_BUSY_REFUSE: assert property (i_req.wr && o_busy |=>
    o_ack && o_err)
    else $error("write during a conversion was taken");

  AST_SAVE16: assert property (commit16 |=>
    o_nv_save)
    else $error("word write did not request a save");

  AST_RD_BACK: assert property (i_req.rd && !i_req.wr && hit16[MNPB_IX_VOLT] |=>
    o_rdata == $past(s16_q[MNPB_IX_VOLT]))
    else $error("voltage read did not return the stored word");

  AST_HI_STAGE: assert property (stage_hi |=>
    o_ack && !o_err && hi_pend)
    else $error("high word was not staged");
endmodule // mnpb_nameplate_bank

// ===== sim/mnpb_mb_master.sv
`timescale 1ns/1ns
// holding-register master: one request per call, the answer is taken one cycle later
module mnpb_mb_master import mnpb_pkg::*; (
  input wire logic i_clk_sys, // system clock
  input wire logic i_ack, // answer strobe
  input wire logic i_err, // refusal flag
  input wire logic [15:0] i_rdata, // read word
  output mnpb_req_t o_req // request to the bank
);
  initial begin
    o_req = '0;
  end
  // a released bus shows inverted address and data, so a stale word can never pass for a fresh one
  task automatic xfer(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d,
                      output logic e, output logic [15:0] q, output logic k);
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: w, rd: r, addr: a, data: d};
    @(posedge i_clk_sys);
    #1;
    k = i_ack;
    e = i_err;
    q = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule // mnpb_mb_master

// ===== sim/mnpb_nameplate_bank_bench.sv
`timescale 1ns/1ns
module mnpb_nameplate_bank_bench import mnpb_pkg::*;;
  logic clk, rst, restore, ct_fit, ack, err, busy, save, e, k;
  logic [15:0] rdata, ctp, cts, q;
  mnpb_req_t req;
  mnpb_image_t nv_img, img, snap;
  int errors = 0;
  int check_count = 0;
  int saves = 0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // counts store triggers so retention can be judged
  always @(posedge clk) if (save === 1'b1) saves <= saves + 1;

  mnpb_nameplate_bank mnpb_nameplate_bank_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_req(req), .o_ack(ack),
    .o_err(err), .o_rdata(rdata), .o_busy(busy), .i_nv_restore(restore), .i_nv_image(nv_img), .o_image(img),
    .o_nv_save(save), .i_ext_ct_fitted(ct_fit), .o_ct_primary(ctp), .o_ct_secondary(cts));
  mnpb_mb_master mnpb_mb_master_i (.i_clk_sys(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata), .o_req(req));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic x);
    mnpb_mb_master_i.xfer(1'b1, 1'b0, a, d, e, q, k);
    chk("wr_ack", k, 1);
    chk("wr_err", e, x);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    mnpb_mb_master_i.xfer(1'b0, 1'b1, a, 16'h0000, e, q, k);
    chk("rd_ack", k, 1);
    chk("rd_err", e, 0);
    chk("rdata", q, x);
  endtask
  // high word is staged first, the low word commits the pair
  task automatic wr32(input logic [15:0] a, input logic [31:0] v, input logic x);
    wr(a, v[31:16], 1'b0);
    wr(a + 16'h0001, v[15:0], x);
  endtask
  task automatic rd32(input logic [15:0] a, input logic [31:0] x);
    rd(a, x[31:16]);
    rd(a + 16'h0001, x[15:0]);
  endtask
  // bounded wait for the conversion to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy_end", n < 60, 1);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask

  task automatic t_defaults;
    for (int i = 0; i < 9; i++) begin
      rd(MNPB_S16_ADDR[i], MNPB_S16_RST[i]);
    end
    for (int j = 0; j < 4; j++) begin
      rd32(MNPB_L32_ADDR[j], MNPB_L32_RST[j]);
    end
    chk("ct_pri_rst", ctp, 1);
  endtask
  // below, above and at the bottom of every bounded 16-bit span, then unmapped places
  task automatic t_span;
    for (int i = 0; i < 6; i++) begin
      wr(MNPB_S16_ADDR[i], MNPB_S16_MIN[i] - 16'h0001, 1'b1);
      wr(MNPB_S16_ADDR[i], MNPB_S16_MAX[i] + 16'h0001, 1'b1);
      rd(MNPB_S16_ADDR[i], MNPB_S16_RST[i]);
      wr(MNPB_S16_ADDR[i], MNPB_S16_MIN[i], 1'b0);
      rd(MNPB_S16_ADDR[i], MNPB_S16_MIN[i]);
    end
    wr(MNPB_S16_ADDR[2], 16'hec78, 1'b1);
    rd(MNPB_S16_ADDR[2], MNPB_S16_MIN[2]);
    wr(16'h0398, 16'h0001, 1'b1);
    mnpb_mb_master_i.xfer(1'b0, 1'b1, 16'h0386, 16'h0000, e, q, k);
    chk("unmapped_err", e, 1);
  endtask
  // one horsepower is 745.7 watts; horsepower words are written in hundredths
  task automatic t_conv;
    wr32(MNPB_L32_ADDR[0], 32'd7457, 1'b0);
    chk("busy", busy, 1);
    wait_idle();
    rd32(MNPB_L32_ADDR[2], 32'd1000);
    wr32(MNPB_L32_ADDR[1], 32'd3728500, 1'b0);
    wait_idle();
    rd32(MNPB_L32_ADDR[3], 32'd500000);
    wr32(MNPB_L32_ADDR[2], 32'd12325, 1'b0);
    wr(MNPB_S16_ADDR[0], 16'h01f4, 1'b1);
    wait_idle();
    rd32(MNPB_L32_ADDR[0], 32'd91907);
    wr32(MNPB_L32_ADDR[3], 32'd1, 1'b0);
    wait_idle();
    rd32(MNPB_L32_ADDR[1], 32'd10);
    wr32(MNPB_L32_ADDR[0], 32'd3728501, 1'b1);
    wr(MNPB_L32_ADDR[0] + 16'h0001, 16'h0005, 1'b1);
    rd32(MNPB_L32_ADDR[0], 32'd91907);
    wr32(MNPB_L32_ADDR[3], 32'd200, 1'b0);
    wait_idle();
    rd32(MNPB_L32_ADDR[1], 32'd1491);
    wr32(MNPB_L32_ADDR[3], 32'd500001, 1'b1);
    wr32(MNPB_L32_ADDR[2], 32'd0, 1'b1);
    rd32(MNPB_L32_ADDR[3], 32'd200);
    rd32(MNPB_L32_ADDR[2], 32'd12325);
  endtask
  task automatic t_ct;
    wr(MNPB_S16_ADDR[7], 16'h0005, 1'b0);
    wr(MNPB_S16_ADDR[8], 16'h0007, 1'b0);
    chk("ct_pri_off", ctp, 1);
    chk("ct_sec_off", cts, 1);
    ct_fit = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ct_pri_on", ctp, 5);
    chk("ct_sec_on", cts, 7);
  endtask
  // a power cycle loses the live image; restore must bring back what was saved
  task automatic t_nv;
    int s;
    s = saves;
    wr(MNPB_S16_ADDR[6], 16'h0123, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("save_pulse", saves, s + 1);
    snap = img;
    do_reset();
    chk("res_rst", img.s16[6], 16'h0118);
    nv_img = snap;
    restore = 1'b1;
    @(posedge clk);
    #1;
    restore = 1'b0;
    rd(MNPB_S16_ADDR[6], 16'h0123);
    for (int i = 0; i < 9; i++) begin
      chk("img_s16", img.s16[i], snap.s16[i]);
    end
    for (int j = 0; j < 4; j++) begin
      chk("img_l32", img.l32[j], snap.l32[j]);
    end
  endtask

  initial begin
    rst = 1'b1;
    restore = 1'b0;
    ct_fit = 1'b0;
    nv_img = '0;
    do_reset();
    t_defaults();
    t_span();
    t_conv();
    t_ct();
    t_nv();
    stop_test();
  end
  // the tests need well under a thousand cycles; this span leaves wide margin
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule // mnpb_nameplate_bank_bench
